//--- rtl/afc_pkg.sv
// Constants, types and field layout of the receive FIFO automatic flow controller
//------------------------------------------------------------------------------
// Functional notes
// RQ1: Every-frame mode: jam or pause once threshold reached
// RQ2: Full-duplex flow control needs every-frame bit set
// RQ3: Half-duplex every-frame mode ignores destination address
// RQ4: Half-duplex every-frame: react at valid preamble
// RQ5: Full-duplex: request pause immediately at threshold
// RQ6: Pending pause held until MAC takes it
// RQ7: Every-frame bit overrides multicast/broadcast/address bits
// RQ8: Four-bit selector sets jam time, speed dependent
// RQ9: High threshold counts in 64-byte units
// RQ10: One pause frame per high threshold crossing
// RQ11: Zero-time pause below low threshold after pause
// RQ12: Half-duplex matching frames jammed for selected time
// RQ13: Jam time counted in device clocks from selector
//------------------------------------------------------------------------------
package afc_pkg;

   //------------------------------------------------------------------------------
   // Register map (byte addresses on the Wishbone bus)
   //------------------------------------------------------------------------------
   localparam logic [7:0]  AFC_CTRL_OFS   = 8'h00;       // Thresholds, duration and mode bits
   localparam logic [7:0]  AFC_PAUSE_OFS  = 8'h04;       // Pause time for the first pause frame
   localparam logic [7:0]  AFC_STAT_OFS   = 8'h08;       // Read-only controller state
   localparam logic [31:0] AFC_CTRL_RST   = 32'h0000_0000;
   localparam logic [15:0] AFC_PAUSE_RST  = 16'h0000;

   // Control register field positions
   localparam int FIFO_HIGH_THRESHOLD_LSB     = 16;                   // fifo_high_threshold [23:16]
   localparam int FIFO_LOW_THRESHOLD_LSB     = 8;                    // fifo_low_threshold [15:8]
   localparam int AFC_DUR_LSB    = 4;                    // jam_duration_select [7:4]
   localparam int AFC_MULT_BIT   = 3;                    // flow_ctl_on_multicast
   localparam int AFC_BRD_BIT    = 2;                    // flow_ctl_on_broadcast
   localparam int AFC_ADDR_BIT   = 1;                    // flow_ctl_on_address_match
   localparam int AFC_ANY_BIT    = 0;                    // flow_ctl_on_every_frame
   localparam logic [31:0] AFC_CTRL_MASK = 32'h00ff_ffff; // Writable bits of control

   // Status register field positions
   localparam int AFC_ST_HI_BIT   = 0;                   // Level at or above high threshold
   localparam int AFC_ST_SENT_BIT = 1;                   // Pause sent, waiting for low level
   localparam int AFC_ST_JAM_BIT  = 2;                   // Back pressure active
   localparam int AFC_ST_REQ_BIT  = 3;                   // Pause request pending at MAC

   //------------------------------------------------------------------------------
   // FIFO level and timing
   //------------------------------------------------------------------------------
   localparam int AFC_LEVEL_W       = 15;                // Receive FIFO fill in bytes
   localparam int AFC_THR_SHIFT     = 6;                 // Threshold unit of 64 bytes
   localparam int AFC_CLK_PERIOD_NS = 100;               // 10 MHz device clock
   localparam int AFC_JAM_SHORT_NS  = 5000;              // Codes 0..2 step of 5 us
   localparam int AFC_JAM_CODE3_NS  = 25000;             // Code 3 is 25 us
   localparam int AFC_JAM_STEP_NS   = 50000;             // Codes 4..f step of 50 us
   localparam int AFC_JAM_SLOW_NS   = 2200;              // Extra 2.2 us at 10 Mb/s
   localparam int AFC_JAM_CNT_W     = 14;                // Jam counter width

   // Full-duplex pause sequencer, Gray coded along the normal path
   typedef enum logic [1:0] {
      AFC_IDLE   = 2'b00,                                // Waiting for high threshold
      AFC_PAUSE  = 2'b01,                                // Pause with programmed time pending
      AFC_PAUSED = 2'b11,                                // Pause sent, waiting for low level
      AFC_RESUME = 2'b10                                 // Zero-time pause pending
   } afc_fd_st_t;

endpackage

//--- rtl/afc_jam_if.sv
// Handshake between the flow controller and its back-pressure timer
`timescale 1ns/1ps
interface afc_jam_if;
   logic       start;                                    // One-cycle request to begin jamming
   logic [3:0] code;                                     // Duration selector
   logic       fast;                                     // High when link runs at 100 Mb/s
   logic       busy;                                     // Jamming in progress (flop)

   modport ctrl (output start, output code, output fast, input busy);
   modport tmr  (input start, input code, input fast, output busy);
endinterface

//--- rtl/afc_jam_timer.sv
// Back-pressure duration timer counted in device clocks
`timescale 1ns/1ps
module afc_jam_timer #(
   parameter int JAM_STEP_NS = 50000                     // Long step, shortened in simulation
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // Request from the controller
   afc_jam_if.tmr    jif
);
   import afc_pkg::*;

   //------------------------------------------------------------------------------
   // Duration lookup
   //------------------------------------------------------------------------------
   // Time in ns for a selector code and link speed, then in whole clocks
   function automatic logic [AFC_JAM_CNT_W-1:0] jam_cycles(input logic [3:0] c, input logic f);
      int ns;
      int cyc;
      if (c < 4'h3) begin
         ns = (int'(c) + 1) * AFC_JAM_SHORT_NS;
      end else if (c == 4'h3) begin
         ns = AFC_JAM_CODE3_NS;
      end else begin
         ns = (int'(c) - 3) * JAM_STEP_NS;
      end
      if (!f) begin
         ns = ns + AFC_JAM_SLOW_NS;
      end
      cyc = (ns + AFC_CLK_PERIOD_NS - 1) / AFC_CLK_PERIOD_NS;
      if (cyc < 1) begin
         cyc = 1;
      end
      return AFC_JAM_CNT_W'(cyc);
   endfunction

   logic [AFC_JAM_CNT_W-1:0] load_w;                     // Length of the next jam
   logic [AFC_JAM_CNT_W-1:0] cnt_r;                      // Cycles left minus one
   logic                     busy_r;                     // Jam active
   logic [AFC_JAM_CNT_W-1:0] len_r;                      // Length of current jam (checking)
   logic [AFC_JAM_CNT_W:0]   run_r;                      // Cycles counted (checking)
   logic                     go_w;                       // Accepted start

   assign load_w   = jam_cycles(jif.code, jif.fast);     // see RQ8
   assign go_w     = jif.start && !busy_r;
   assign jif.busy = busy_r;

   //------------------------------------------------------------------------------
   // Countdown
   //------------------------------------------------------------------------------
   // Load on start, count down to zero, then release
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
      end else if (go_w) begin
         cnt_r  <= load_w - AFC_JAM_CNT_W'(1);           // see RQ13
         busy_r <= 1'b1;
      end else if (busy_r) begin
         busy_r <= (cnt_r != '0);
         cnt_r  <= (cnt_r != '0) ? cnt_r - AFC_JAM_CNT_W'(1) : cnt_r;
      end
   end

   // Helper counters for the length check
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         len_r <= '0;
         run_r <= '0;
      end else if (go_w) begin
         len_r <= load_w;
         run_r <= (AFC_JAM_CNT_W+1)'(1);
      end else if (busy_r) begin
         run_r <= run_r + (AFC_JAM_CNT_W+1)'(1);
      end
   end

   jam_length_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see RQ8
      $fell(busy_r) |-> run_r == {1'b0, len_r} + (AFC_JAM_CNT_W+1)'(1))
      else $error("jam length differs from selected duration");

endmodule

//--- rtl/afc_top.sv
// Receive FIFO automatic flow controller with Wishbone register access
`timescale 1ns/1ps
module afc_top #(
   parameter int JAM_STEP_NS = afc_pkg::AFC_JAM_STEP_NS  // Long jam step in ns
) (
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         rstn_i,
   // Wishbone classic slave
   input  wire logic                         wb_cyc_i,
   input  wire logic                         wb_stb_i,
   input  wire logic                         wb_we_i,
   input  wire logic [7:0]                   wb_adr_i,
   input  wire logic [3:0]                   wb_sel_i,
   input  wire logic [31:0]                  wb_dat_i,
   output logic      [31:0]                  wb_dat_o,
   output logic                              wb_ack_o,
   // Receive side status
   input  wire logic [afc_pkg::AFC_LEVEL_W-1:0] fifo_level_i,
   input  wire logic                         full_duplex_i,
   input  wire logic                         speed_100_i,
   input  wire logic                         rx_preamble_i,
   input  wire logic                         rx_addr_valid_i,
   input  wire logic                         rx_is_mcast_i,
   input  wire logic                         rx_is_bcast_i,
   input  wire logic                         rx_addr_match_i,
   // Requests to the MAC
   output logic                              jam_o,
   output logic                              pause_req_o,
   output logic      [15:0]                  pause_time_o,
   input  wire logic                         pause_ack_i
);
   import afc_pkg::*;

   //------------------------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------------------------
   // Threshold field to a byte count
   function automatic logic [AFC_LEVEL_W-1:0] thr_bytes(input logic [7:0] t);
      return AFC_LEVEL_W'({t, 6'h00});
   endfunction

   // Byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   //------------------------------------------------------------------------------
   // Registers and decode
   //------------------------------------------------------------------------------
   logic [31:0] ctrl_r;                                  // Control register
   logic [15:0] ptime_r;                                 // pause_time_value
   logic        ack_r;                                   // Bus acknowledge
   logic [31:0] dat_r;                                   // Read data
   logic        req_w;                                   // New bus request
   logic        wr_ctrl_w;                               // Write to control
   logic        wr_pause_w;                              // Write to pause time
   logic [31:0] rd_mux_w;                                // Selected read word
   logic [31:0] stat_w;                                  // Status word

   assign req_w      = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr_ctrl_w  = req_w && wb_we_i && (wb_adr_i == AFC_CTRL_OFS);
   assign wr_pause_w = req_w && wb_we_i && (wb_adr_i == AFC_PAUSE_OFS);

   // Pause time merged with the write data, low half kept
   logic [31:0] ptime_mrg_w;                             // Merged pause time word
   assign ptime_mrg_w = merge({16'h0000, ptime_r}, wb_dat_i, wb_sel_i);

   // Mode and field views of the control register
   logic [7:0]  hi_thr_w;                                // fifo_high_threshold
   logic [7:0]  lo_thr_w;                                // fifo_low_threshold
   logic [3:0]  dur_w;                                   // jam_duration_select
   logic        any_w;                                   // flow_ctl_on_every_frame
   logic        mult_w;                                  // flow_ctl_on_multicast
   logic        brd_w;                                   // flow_ctl_on_broadcast
   logic        addr_w;                                  // flow_ctl_on_address_match

   assign hi_thr_w = ctrl_r[FIFO_HIGH_THRESHOLD_LSB +: 8];
   assign lo_thr_w = ctrl_r[FIFO_LOW_THRESHOLD_LSB +: 8];
   assign dur_w    = ctrl_r[AFC_DUR_LSB +: 4];
   assign any_w    = ctrl_r[AFC_ANY_BIT];
   assign mult_w   = ctrl_r[AFC_MULT_BIT];
   assign brd_w    = ctrl_r[AFC_BRD_BIT];
   assign addr_w   = ctrl_r[AFC_ADDR_BIT];

   // Register writes honour byte enables
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         ctrl_r  <= AFC_CTRL_RST;
         ptime_r <= AFC_PAUSE_RST;
      end else begin
         if (wr_ctrl_w) begin
            ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i) & AFC_CTRL_MASK;
         end
         if (wr_pause_w) begin
            ptime_r <= ptime_mrg_w[15:0];
         end
      end
   end

   //------------------------------------------------------------------------------
   // Threshold detection
   //------------------------------------------------------------------------------
   logic hi_w;                                           // Level reached high threshold
   logic lo_w;                                           // Level fell below low threshold
   logic fd_en_w;                                        // Full-duplex flow control active
   logic hd_w;                                           // Half-duplex operation

   assign hi_w    = fifo_level_i >= thr_bytes(hi_thr_w); // see RQ9
   assign lo_w    = fifo_level_i <  thr_bytes(lo_thr_w);
   assign fd_en_w = any_w && full_duplex_i;              // see RQ2
   assign hd_w    = !full_duplex_i;

   //------------------------------------------------------------------------------
   // Half-duplex back pressure
   //------------------------------------------------------------------------------
   afc_jam_if jif ();

   logic crit_w;                                         // Selected address criteria met
   logic jam_go_w;                                       // Start a jam this cycle

   // Every-frame mode overrides the three selection bits
   assign crit_w   = (mult_w && rx_is_mcast_i) || (brd_w && rx_is_bcast_i)
                     || (addr_w && rx_addr_match_i);     // see RQ7
   // Every-frame mode reacts to the preamble, no address decode needed
   assign jam_go_w = hd_w && hi_w && !jif.busy &&
                     (any_w ? rx_preamble_i              // see RQ1, RQ3, RQ4
                            : (rx_addr_valid_i && crit_w)); // see RQ12
   assign jif.start = jam_go_w;
   assign jif.code  = dur_w;                             // see RQ8
   assign jif.fast  = speed_100_i;
   assign jam_o     = jif.busy;                          // Timer output flop

   afc_jam_timer #(
      .JAM_STEP_NS (JAM_STEP_NS)
   ) u_timer (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .jif    (jif.tmr)
   );

   //------------------------------------------------------------------------------
   // Full-duplex pause sequencer
   //------------------------------------------------------------------------------
   afc_fd_st_t  st_r;                                    // Sequencer state
   afc_fd_st_t  st_nxt;
   logic        req_r;                                   // Pause request to MAC
   logic        req_nxt;
   logic [15:0] tim_r;                                   // Pause time offered
   logic [15:0] tim_nxt;

   // Next-state logic
   always_comb begin
      st_nxt  = st_r;
      req_nxt = req_r;
      tim_nxt = tim_r;
      case (st_r)
         AFC_IDLE: begin
            // Ask for a pause at once, no frame needed
            if (fd_en_w && hi_w) begin                   // see RQ1, RQ5
               st_nxt  = AFC_PAUSE;
               req_nxt = 1'b1;
               tim_nxt = ptime_r;                        // see RQ10
            end
         end
         AFC_PAUSE: begin
            // Hold the request until the MAC takes it
            if (pause_ack_i) begin                       // see RQ6
               st_nxt  = AFC_PAUSED;
               req_nxt = 1'b0;
            end
         end
         AFC_PAUSED: begin
            // No second pause while level stays high
            if (!fd_en_w) begin                          // see RQ10
               st_nxt = AFC_IDLE;
            end else if (lo_w) begin                     // see RQ11
               st_nxt  = AFC_RESUME;
               req_nxt = 1'b1;
               tim_nxt = 16'h0000;
            end
         end
         AFC_RESUME: begin
            if (pause_ack_i) begin                       // see RQ6
               st_nxt  = AFC_IDLE;
               req_nxt = 1'b0;
            end
         end
         default: begin
            st_nxt  = AFC_IDLE;
            req_nxt = 1'b0;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_r  <= AFC_IDLE;
         req_r <= 1'b0;
         tim_r <= 16'h0000;
      end else begin
         st_r  <= st_nxt;
         req_r <= req_nxt;
         tim_r <= tim_nxt;
      end
   end

   assign pause_req_o  = req_r;
   assign pause_time_o = tim_r;

   //------------------------------------------------------------------------------
   // Bus read and acknowledge
   //------------------------------------------------------------------------------
   // Status word built from the package bit positions
   always_comb begin
      stat_w                  = 32'h0000_0000;
      stat_w[AFC_ST_HI_BIT]   = hi_w;
      stat_w[AFC_ST_SENT_BIT] = (st_r == AFC_PAUSED);
      stat_w[AFC_ST_JAM_BIT]  = jif.busy;
      stat_w[AFC_ST_REQ_BIT]  = req_r;
   end

   // Address decode, unmapped reads return zero
   assign rd_mux_w = (wb_adr_i == AFC_CTRL_OFS)  ? ctrl_r :
                     (wb_adr_i == AFC_PAUSE_OFS) ? {16'h0000, ptime_r} :
                     (wb_adr_i == AFC_STAT_OFS)  ? stat_w : 32'h0000_0000;

   // One acknowledge per request, one cycle after it is seen
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         ack_r <= req_w;
         dat_r <= req_w ? rd_mux_w : dat_r;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

   //------------------------------------------------------------------------------
   // Checks
   //------------------------------------------------------------------------------
   ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   fd_needs_any_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see RQ2
      $rose(pause_req_o) |-> $past(any_w) && $past(full_duplex_i))
      else $error("pause requested without full-duplex every-frame mode");

   hd_preamble_jam_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see RQ4
      (hd_w && any_w && hi_w && rx_preamble_i && !jam_o) |=> jam_o)
      else $error("preamble at threshold did not start jamming");

   fd_pause_now_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see RQ5
      (st_r == AFC_IDLE && fd_en_w && hi_w) |=> pause_req_o && pause_time_o == $past(ptime_r))
      else $error("pause not requested at threshold");

   pause_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see RQ6
      (pause_req_o && !pause_ack_i) |=> pause_req_o && $stable(pause_time_o))
      else $error("pending pause dropped before acceptance");

   single_pause_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see RQ10
      (pause_req_o && pause_ack_i) |=> !pause_req_o)
      else $error("pause request repeated after acceptance");

   zero_pause_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see RQ11
      ($rose(pause_req_o) && st_r == AFC_RESUME) |-> $past(st_r) == AFC_PAUSED && pause_time_o == 16'h0000)
      else $error("zero pause without earlier pause");

   addr_match_jam_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see RQ12
      (hd_w && !any_w && hi_w && rx_addr_valid_i && addr_w && rx_addr_match_i && !jam_o) |=> jam_o)
      else $error("matching frame not jammed");

   fd_no_jam_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see RQ12
      (full_duplex_i && !jam_o) |=> !jam_o)
      else $error("back pressure started in full duplex");

   hd_no_pause_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see RQ2
      (!full_duplex_i && st_r == AFC_IDLE) |=> !pause_req_o)
      else $error("pause requested in half duplex");

   any_no_addr_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see RQ3, RQ7
      (hd_w && any_w && !rx_preamble_i && !jam_o) |=> !jam_o)
      else $error("address decode started jam in every-frame mode");

   below_hi_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see RQ9
      (!hi_w && !jam_o) |=> !jam_o)
      else $error("jam started below high threshold");

   low_resume_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // see RQ11
      (st_r == AFC_PAUSED && fd_en_w && lo_w) |=> pause_req_o && pause_time_o == 16'h0000)
      else $error("zero pause not requested below low threshold");

endmodule

//--- bench/afc_mac_model.sv
// Behavioural MAC that takes pause frame requests after a set delay
`timescale 1ns/1ps
module afc_mac_model (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // Pause request from the flow controller
   input  wire logic        req_i,
   input  wire logic [15:0] time_i,
   input  wire logic [3:0]  delay_i,
   output logic             ack_o,
   // Observations for the bench
   output logic [7:0]       taken_o,
   output logic [15:0]      last_o,
   output logic             moved_o
);
   logic [3:0]  wait_r;                                  // Cycles the current request has waited
   logic [15:0] time_r;                                  // Pause time seen one cycle ago

   // Wait for a free transmit slot, then take the pending pause frame
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         ack_o   <= 1'b0;
         wait_r  <= 4'h0;
         taken_o <= 8'h00;
         last_o  <= 16'h0000;
         moved_o <= 1'b0;
      end else begin
         ack_o  <= 1'b0;
         time_r <= time_i;
         if (req_i && !ack_o) begin
            // Slot found: send the frame without cutting one short
            if (wait_r == delay_i) begin
               ack_o   <= 1'b1;
               wait_r  <= 4'h0;
               taken_o <= taken_o + 8'h01;
               last_o  <= time_i;
            end else begin
               wait_r <= wait_r + 4'h1;
            end
         end
         // Pause time must not move while the request waits
         if (req_i && wait_r != 4'h0 && time_i !== time_r) begin
            moved_o <= 1'b1;
         end
      end
   end
endmodule

//--- bench/tb_top.sv
// Self-checking bench of the receive FIFO automatic flow controller
`timescale 1ns/1ps
module tb_top;
   import afc_pkg::*;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
   localparam int STEP = 5000;                           // Shortened long jam step in ns
   logic        clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic        pre = 1'b0, av = 1'b0, mc = 1'b0, bc = 1'b0, am = 1'b0;
   logic        fd = 1'b0, fast = 1'b1, jam, req, pack, moved;
   logic [7:0]  adr = 8'h00, taken;
   logic [3:0]  dly = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [14:0] level = 15'h0;
   logic [15:0] ptime, last;
   int          n_fail = 0, checked = 0, cycles = 0, n, c;

   always #50 clk_i = ~clk_i;

   afc_top #(.JAM_STEP_NS(STEP)) uut (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .fifo_level_i(level),
      .full_duplex_i(fd), .speed_100_i(fast), .rx_preamble_i(pre), .rx_addr_valid_i(av), .rx_is_mcast_i(mc),
      .rx_is_bcast_i(bc), .rx_addr_match_i(am), .jam_o(jam), .pause_req_o(req), .pause_time_o(ptime),
      .pause_ack_i(pack));
   afc_mac_model mac (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req), .time_i(ptime), .delay_i(dly), .ack_o(pack),
      .taken_o(taken), .last_o(last), .moved_o(moved));

   // Verdict and end of run
   task stop_test;
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Cut a hang short
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 30000) begin
         n_fail++;
         stop_test();
      end
   end

   // Classic Wishbone single access, held until ack
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask

   // One-cycle preamble or address decode pulse with match flags
   task pulse(input logic p, input logic [2:0] m);
      @(posedge clk_i);
      pre <= p; av <= ~p; {mc, bc, am} <= m;
      @(posedge clk_i);
      pre <= 1'b0; av <= 1'b0; {mc, bc, am} <= 3'b000;
   endtask

   // Count cycles of back pressure following a trigger
   task jam_len(output int len);
      int k;
      len = 0;
      for (k = 0; k < 8000; k++) begin
         @(posedge clk_i);
         if (jam === 1'b1) len++;
         else if (len > 0 || k > 2) break;
      end
   endtask

   function int exp_n(input int code, input logic f);
      exp_n = code < 3 ? (code + 1) * 50 : code == 3 ? 250 : (code - 3) * (STEP / 100);
      if (!f) exp_n += 22;
   endfunction

   initial begin
      repeat (4) @(posedge clk_i);
      rstn_i <= 1'b1;
      rd(AFC_CTRL_OFS, AFC_CTRL_RST);
      rd(AFC_PAUSE_OFS, 32'h0);
      rd(8'h0c, 32'h0);
      wb(1'b1, AFC_CTRL_OFS, 32'hffff_ffff);
      rd(AFC_CTRL_OFS, AFC_CTRL_MASK);
      // Half duplex, level exactly at 2*64 bytes, every code at both speeds
      level <= 15'd128;
      for (c = 0; c < 32; c++) begin
         fast <= c[0];
         wb(1'b1, AFC_CTRL_OFS, {8'h00, 8'h02, 8'h01, c[4:1], 4'h1});
         pulse(1'b1, 3'b000);
         jam_len(n);
         `CHK(n, exp_n(c / 2, c[0]))
      end
      wb(1'b1, AFC_CTRL_OFS, 32'h0002_010f);
      pulse(1'b0, 3'b111);
      jam_len(n);
      `CHK(n, 0)
      wb(1'b1, AFC_CTRL_OFS, 32'h0002_0108);
      pulse(1'b0, 3'b100);
      jam_len(n);
      `CHK(n, 50)
      pulse(1'b0, 3'b011);
      jam_len(n);
      `CHK(n, 0)
      wb(1'b1, AFC_CTRL_OFS, 32'h0002_0106);
      pulse(1'b0, 3'b001);
      jam_len(n);
      `CHK(n, 50)
      pulse(1'b0, 3'b010);
      jam_len(n);
      `CHK(n, 50)
      level <= 15'd127;
      wb(1'b1, AFC_CTRL_OFS, 32'h0002_0101);
      pulse(1'b1, 3'b000);
      jam_len(n);
      `CHK(n, 0)
      wb(1'b1, AFC_STAT_OFS, 32'hffff_ffff);
      rd(AFC_STAT_OFS, 32'h0);
      // Full duplex pause sequence with a slow MAC
      wb(1'b1, AFC_CTRL_OFS, 32'h0002_0100);
      fd <= 1'b1; dly <= 4'h3; level <= 15'd128;
      wb(1'b1, AFC_PAUSE_OFS, 32'h0000_1234);
      repeat (10) @(posedge clk_i);
      `CHK(taken, 8'd0)
      wb(1'b1, AFC_CTRL_OFS, 32'h0002_0101);
      repeat (40) @(posedge clk_i);
      `CHK(taken, 8'd1)
      `CHK(last, 16'h1234)
      pulse(1'b1, 3'b000);
      jam_len(n);
      `CHK(n, 0)
      level <= 15'd64;
      repeat (10) @(posedge clk_i);
      `CHK(taken, 8'd1)
      level <= 15'd63;
      repeat (20) @(posedge clk_i);
      `CHK(taken, 8'd2)
      `CHK(last, 16'h0000)
      `CHK(moved, 1'b0)
      // Prompt MAC: request must follow the level at once
      dly <= 4'h0; level <= 15'd128;
      @(posedge clk_i);
      @(negedge clk_i);
      `CHK(req, 1'b1)
      repeat (5) @(posedge clk_i);
      `CHK(taken, 8'd3)
      stop_test();
   end
endmodule
